// ### hdl/scs_cfg.svh
// constants for the start-up configuration selector
// assumes a 200 MHz system clock
`ifndef SCS_CFG_SVH
`define SCS_CFG_SVH
`define SCS_CLK_MHZ 200
`define SCS_SETTLE_US 1000
`define SCS_SETTLE_CYC (`SCS_SETTLE_US * `SCS_CLK_MHZ)
`define SCS_SETTLE_LAST 32'h1
`define SCS_BOOT_LAST 2'h2
`define SCS_CFG_W 2
`define SCS_CFG_ZERO 2'h0
`define SCS_SRC_OTP 1'h0
`define SCS_SRC_SERIAL 1'h1
`endif

// ### hdl/scs_pkg.sv
// types for the start-up configuration selector
// no assumptions beyond the cfg header
package scs_pkg;
  typedef enum logic [1:0] {SCS_ST_BOOT, SCS_ST_LOAD, SCS_ST_RUN} scs_state_t;
endpackage

// ### hdl/scs_top.sv
// start-up mode and configuration selection of a clock generator
// assumes RST_N_I is the internal power-on reset; straps and selects are asynchronous pins
//
// Overview of operation
// [R01] mode strap low at reset: software mode, serial interface stays open
// [R02] mode strap high at reset: hardware-select mode, load stored config, block serial access
// [R03] hardware-select: select pins high,low give configuration 0 to 3
// [R04] software mode: stored bit set loads serial defaults, clear loads configuration 0
// [R05] host holds both select pins stable through power-on reset
// [R06] host changes select pins only after first 10ms of operation
// [R07] host changes only one select pin per transition
// [R08] after select change device loads new config; host waits at least 1ms
// [R09] hardware-select mode: divider sync reset issued at power-on reset
// [R10] divider sync reset reissued on every select pin configuration switch
// [R11] mode strap captured once after reset, held until next reset
`timescale 1ns/1ps
`include "scs_cfg.svh"
module scs_top #(
  parameter int SETTLE_CYC = `SCS_SETTLE_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic MODE_STRAP_PIN_I,
  input wire logic CONFIG_SELECT_LOW_I,
  input wire logic CONFIG_SELECT_HIGH_I,
  input wire logic LOAD_STORED_AT_POWERUP_BIT_I,
  output logic SOFTWARE_MODE_O,
  output logic SERIAL_ACCESS_EN_O,
  output logic LOAD_REQ_O,
  output logic LOAD_SRC_SERIAL_O,
  output logic [1:0] CONFIG_SEL_O,
  output logic DIV_SYNC_RST_O,
  output logic LOAD_BUSY_O
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {MODE_STRAP_PIN_I, CONFIG_SELECT_HIGH_I, CONFIG_SELECT_LOW_I};
      sync2_q <= sync1_q;
    end
  end

  logic strap_s;
  logic [1:0] sel_s;
  assign strap_s = sync2_q[2];
  assign sel_s = sync2_q[1:0]; // high pin in bit 1, low pin in bit 0

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  scs_pkg::scs_state_t state_q;
  logic [1:0] boot_cnt_q;
  logic [31:0] settle_cnt_q;
  logic hw_mode_q;
  logic [1:0] cfg_q;
  logic boot_done;
  logic sel_change;
  logic settle_done;
  logic start_load;
  logic hw_now;
  logic mode_known;

  // boot ends once the synchronisers hold settled pin levels
  assign boot_done = (state_q == scs_pkg::SCS_ST_BOOT) && (boot_cnt_q == `SCS_BOOT_LAST);
  // a new select level is only taken while running in hardware-select mode
  assign sel_change = (state_q == scs_pkg::SCS_ST_RUN) && hw_mode_q && (sel_s != cfg_q); // [R08] [R10]
  assign settle_done = (settle_cnt_q <= `SCS_SETTLE_LAST);
  assign start_load = boot_done || sel_change;
  // mode in force: the live strap while booting, the captured one afterwards
  assign hw_now = (state_q == scs_pkg::SCS_ST_BOOT) ? strap_s : hw_mode_q;
  assign mode_known = (state_q != scs_pkg::SCS_ST_BOOT) || boot_done;

  // boot, then load and settle, then run until a select change
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      state_q <= scs_pkg::SCS_ST_BOOT;
    end
    else
    begin
      unique case (state_q)
        scs_pkg::SCS_ST_BOOT:
        begin
          if (boot_done)
          begin
            state_q <= scs_pkg::SCS_ST_LOAD;
          end
        end
        scs_pkg::SCS_ST_LOAD:
        begin
          if (settle_done)
          begin
            state_q <= scs_pkg::SCS_ST_RUN;
          end
        end
        scs_pkg::SCS_ST_RUN:
        begin
          if (sel_change) // [R08]
          begin
            state_q <= scs_pkg::SCS_ST_LOAD;
          end
        end
        default:
        begin
          state_q <= scs_pkg::SCS_ST_BOOT; // unused code, restart safely
        end
      endcase
    end
  end

  // counts the cycles the pin synchronisers need to fill
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      boot_cnt_q <= 2'h0;
    end
    else if (state_q == scs_pkg::SCS_ST_BOOT && !boot_done)
    begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
    end
  end

  // settle time of a load: reloaded on every start, counted down while loading
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      settle_cnt_q <= 32'h0;
    end
    else if (start_load)
    begin
      settle_cnt_q <= 32'(SETTLE_CYC); // [R08]
    end
    else if (state_q == scs_pkg::SCS_ST_LOAD && !settle_done)
    begin
      settle_cnt_q <= settle_cnt_q - 32'h1;
    end
  end

  // mode captured once, at leaving boot
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      hw_mode_q <= 1'h0;
    end
    else if (boot_done)
    begin
      hw_mode_q <= strap_s; // [R11]
    end
  end

  // selected configuration and its source

  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      cfg_q <= `SCS_CFG_ZERO;
      LOAD_SRC_SERIAL_O <= `SCS_SRC_OTP;
    end
    else if (start_load)
    begin
      if (hw_now)
      begin
        cfg_q <= sel_s; // [R03]
        LOAD_SRC_SERIAL_O <= `SCS_SRC_OTP; // [R02]
      end
      else
      begin
        cfg_q <= `SCS_CFG_ZERO; // [R04]
        LOAD_SRC_SERIAL_O <= LOAD_STORED_AT_POWERUP_BIT_I ? `SCS_SRC_SERIAL : `SCS_SRC_OTP; // [R04]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  // mode outputs settle together with the first load pulse and hold until reset
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      SOFTWARE_MODE_O <= 1'h0;
      SERIAL_ACCESS_EN_O <= 1'h0;
    end
    else
    begin
      SOFTWARE_MODE_O <= mode_known && !hw_now; // [R01]
      SERIAL_ACCESS_EN_O <= mode_known && !hw_now; // [R01] [R02]
    end
  end

  // one-cycle load and divider alignment pulses
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      LOAD_REQ_O <= 1'h0;
      DIV_SYNC_RST_O <= 1'h0;
    end
    else
    begin
      LOAD_REQ_O <= start_load;
      DIV_SYNC_RST_O <= start_load && hw_now; // [R09] [R10]
    end
  end

  // configuration number being or last loaded
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      CONFIG_SEL_O <= `SCS_CFG_ZERO;
    end
    else
    begin
      CONFIG_SEL_O <= start_load ? (hw_now ? sel_s : `SCS_CFG_ZERO) : cfg_q; // [R03] [R04]
    end
  end

  // busy from reset until the settle time of the last load has run out
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      LOAD_BUSY_O <= 1'h1;
    end
    else
    begin
      LOAD_BUSY_O <= (state_q != scs_pkg::SCS_ST_RUN) || start_load; // [R08]
    end
  end

endmodule // scs_top

// ### verification/scs_chk_props.sv
// checker on the start-up selector ports
// assumes it is bound into scs_top
`timescale 1ns/1ps
module scs_chk (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic CONFIG_SELECT_LOW_I,
  input wire logic CONFIG_SELECT_HIGH_I,
  input wire logic LOAD_STORED_AT_POWERUP_BIT_I,
  input wire logic SOFTWARE_MODE_O,
  input wire logic SERIAL_ACCESS_EN_O,
  input wire logic LOAD_REQ_O,
  input wire logic LOAD_SRC_SERIAL_O,
  input wire logic DIV_SYNC_RST_O,
  input wire logic LOAD_BUSY_O,
  input wire logic [1:0] CONFIG_SEL_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // a steady new select seen while idle in hardware-select mode
  sequence s_sel_new;
    !SOFTWARE_MODE_O && !LOAD_BUSY_O && $stable(CONFIG_SELECT_LOW_I) && $stable(CONFIG_SELECT_HIGH_I)
    && {CONFIG_SELECT_HIGH_I, CONFIG_SELECT_LOW_I} != CONFIG_SEL_O;
  endsequence
  // the load of the pins' value together with its alignment pulse
  sequence s_sel_load;
    LOAD_REQ_O && DIV_SYNC_RST_O && CONFIG_SEL_O == {CONFIG_SELECT_HIGH_I, CONFIG_SELECT_LOW_I};
  endsequence
  // quiet busy time after a load pulse; assumes a settle time of at least 8 cycles
  sequence s_settling;
    (!LOAD_REQ_O && LOAD_BUSY_O) [*8];
  endsequence
  a_serial_mode: assert property (SERIAL_ACCESS_EN_O == SOFTWARE_MODE_O) else $error("serial");
  a_sync_hw_only: assert property (DIV_SYNC_RST_O |-> LOAD_REQ_O && !SOFTWARE_MODE_O) else $error("sync");
  a_sync_on_load: assert property (LOAD_REQ_O && !SOFTWARE_MODE_O |-> DIV_SYNC_RST_O) else $error("nosync");
  a_src_by_mode: assert property (LOAD_REQ_O |->
    LOAD_SRC_SERIAL_O == (SOFTWARE_MODE_O && LOAD_STORED_AT_POWERUP_BIT_I)) else $error("src");
  a_sw_cfg_zero: assert property (SOFTWARE_MODE_O |-> CONFIG_SEL_O == 2'h0) else $error("cfg");
  a_mode_held: assert property (!LOAD_BUSY_O |-> $stable(SOFTWARE_MODE_O)) else $error("mode");
  a_load_settle: assert property (LOAD_REQ_O |=> s_settling) else $error("settle");
  a_sel_follow: assert property (s_sel_new [*2] |-> ##[0:3] s_sel_load)
    else $error("sel");
endmodule // scs_chk
bind scs_top scs_chk u_chk (
  .CLK_I(CLK_I),
  .RST_N_I(RST_N_I),
  .CONFIG_SELECT_LOW_I(CONFIG_SELECT_LOW_I),
  .CONFIG_SELECT_HIGH_I(CONFIG_SELECT_HIGH_I),
  .LOAD_STORED_AT_POWERUP_BIT_I(LOAD_STORED_AT_POWERUP_BIT_I),
  .SOFTWARE_MODE_O(SOFTWARE_MODE_O),
  .SERIAL_ACCESS_EN_O(SERIAL_ACCESS_EN_O),
  .LOAD_REQ_O(LOAD_REQ_O),
  .LOAD_SRC_SERIAL_O(LOAD_SRC_SERIAL_O),
  .DIV_SYNC_RST_O(DIV_SYNC_RST_O),
  .LOAD_BUSY_O(LOAD_BUSY_O),
  .CONFIG_SEL_O(CONFIG_SEL_O)
);

// ### verification/scs_host.sv
// board straps and select driver
// moves at most one select pin per clock
`timescale 1ns/1ps
module scs_host (
  input wire logic clk_i,
  input wire logic [2:0] want_i,
  output logic strap_o,
  output logic lo_o,
  output logic hi_o
);
  // walk toward the wanted select one pin at a time
  always_ff @(posedge clk_i)
  begin
    strap_o <= want_i[2];
    if (lo_o !== want_i[0]) lo_o <= want_i[0];
    else hi_o <= want_i[1];
  end
endmodule // scs_host

// ### verification/scs_top_tb_top.sv
// self-checking bench for scs_top
// pins come from the host model
`timescale 1ns/1ps
module scs_top_tb_top;
  logic CLK_I = 0, RST_N_I = 0, bit_q = 0, strap, lo, hi, sw, ser, req, src, sync, busy;
  logic [2:0] want = 0;
  logic [1:0] cfg;
  localparam int SETTLE = 8;
  int fails = 0, cmp_count = 0;
  always #2.5 CLK_I = ~CLK_I;
  scs_host u_host (.clk_i(CLK_I), .want_i(want), .strap_o(strap), .lo_o(lo), .hi_o(hi));
  scs_top #(.SETTLE_CYC(SETTLE)) DUT (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .MODE_STRAP_PIN_I(strap),
    .CONFIG_SELECT_LOW_I(lo), .CONFIG_SELECT_HIGH_I(hi), .LOAD_STORED_AT_POWERUP_BIT_I(bit_q),
    .SOFTWARE_MODE_O(sw), .SERIAL_ACCESS_EN_O(ser), .LOAD_REQ_O(req), .LOAD_SRC_SERIAL_O(src),
    .CONFIG_SEL_O(cfg), .DIV_SYNC_RST_O(sync), .LOAD_BUSY_O(busy));
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(string n, logic [5:0] e, logic [5:0] s);
    cmp_count++;
    if (s !== e) $display("wrong value %s exp %h got %h", n, e, s);
    if (s !== e) fails++;
  endtask
  // wait for a load pulse, or for idle when k is set
  task automatic wt(bit k);
    int i;
    for (i = 0; i < 40 && (k ? busy !== 0 : req !== 1); i++) @(negedge CLK_I);
    if (i == 40) fails++;
    if (i == 40) wrap_up;
  endtask
  // power up with strap, selects and stored bit, check the first load
  task automatic boot(logic [2:0] w, logic b);
    @(posedge CLK_I);
    RST_N_I <= 0;
    want <= w;
    bit_q <= b;
    repeat (8) @(posedge CLK_I);
    RST_N_I <= 1;
    @(negedge CLK_I);
    wt(0);
    chk("boot", {!w[2], !w[2], !w[2] & b, w[2], w[2] ? w[1:0] : 2'h0}, {sw, ser, src, sync, cfg});
  endtask
  // run-time switch with a strap flip that must be ignored, then the busy time of the load
  task automatic swap(logic [1:0] s);
    int n;
    wt(1);
    @(posedge CLK_I);
    want <= {~want[2], s};
    @(negedge CLK_I);
    wt(0);
    chk("switch", {4'h1, s}, {sw, ser, src, sync, cfg});
    for (n = 0; n < 40 && busy !== 0; n++) @(negedge CLK_I);
    chk("busy", 6'(SETTLE + 1), 6'(n));
    if (n == 40) wrap_up;
  endtask
  // software mode ignores the select pins
  task automatic sw_ignore;
    wt(1);
    @(posedge CLK_I);
    want <= 3'h3;
    repeat (12) @(negedge CLK_I) chk("noload", 6'h38, {sw, ser, src, req, cfg});
  endtask
  initial
  begin
    for (int m = 0; m < 16; m++)
      boot(m[2:0], m[3]);
    boot(3'h4, 1'h0);
    swap(2'h1);
    swap(2'h3);
    swap(2'h2);
    swap(2'h0);
    boot(3'h0, 1'h1);
    sw_ignore;
    wrap_up;
  end
endmodule // scs_top_tb_top
